// [rtl/port_error_timeout_reporting.v]
// port error tally, input queue time-out discard and time-out reporting with axi4-lite registers
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "port_error_defines.vh"

// What this block does
// - each end-to-end parity error adds one to the 8-bit tally.
// - the tally stops at all ones and never wraps.
// - reading the tally returns its value then clears it.
// - with time-outs enabled, packets waiting past the core limit are discarded.
// - the time-out enable bit resets to one.
// - bits 1:0 choose posted time-out reporting, reset non-fatal.
// - bits 3:2 choose non-posted time-out reporting, reset none.
// - bits 5:4 choose completion time-out reporting, reset none.
// - codes: 0 none, 1 correctable, 2 non-fatal, 3 fatal message.
// - a report goes out only when a status bit rises.
module port_error_timeout_reporting #(
   parameter AGE_W = 16
) (
   input wire aclk,
   input wire aresetn,
   // axi4-lite slave
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // port core side
   input wire parity_error,
   input wire [2:0] queue_head_valid,
   input wire [2:0] queue_head_pop,
   input wire [AGE_W-1:0] core_timeout_limit,
   output wire [2:0] queue_discard,
   output wire err_msg_valid,
   output wire [1:0] err_msg_code,
   output wire irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   reg awready_q;
   reg wready_q;
   reg aw_held_q;
   reg w_held_q;
   reg [`ADDR_W-1:0] waddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg arready_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;

   reg timeout_enable_q;
   reg [`REPORT_CTRL_W-1:0] report_ctrl_q;
   reg [`EVENT_W-1:0] event_status_q;
   reg [`EVENT_W-1:0] event_status_d;
   reg [`EVENT_W-1:0] event_mask_q;
   reg irq_q;
   reg [2:0] discard_q;
   reg [AGE_W-1:0] age_q [0:2];

   wire [`TALLY_W-1:0] tally;
   wire parity_sync;
   wire aw_take;
   wire w_take;
   wire do_write;
   wire ar_take;
   wire [`ADDR_W-1:0] raddr;
   wire tally_read;
   wire [`EVENT_W-1:0] event_set;
   reg [31:0] read_mux;
   reg read_ok;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode

   // decoder for the write response; the read path decodes in its own case statement
   function known_offset;
      input [`ADDR_W-1:0] addr;
      begin
         known_offset = (addr == `OFF_PARITY_ERROR_COUNT) ||
                        (addr == `OFF_QUEUE_TIMEOUT_ENABLE) ||
                        (addr == `OFF_TIMEOUT_REPORT_CONTROL) ||
                        (addr == `OFF_EVENT_STATUS) ||
                        (addr == `OFF_EVENT_MASK);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // write channel

   assign aw_take = s_axi_awvalid & awready_q;
   assign w_take = s_axi_wvalid & wready_q;
   // address and data may come in either order; the write lands once both are held
   assign do_write = aw_held_q & w_held_q & ~bvalid_q;

   // hold address and data until the response is accepted
   always @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         waddr_q <= {`ADDR_W{1'b0}};
         wdata_q <= `DATA_ZERO;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         if (aw_take) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            waddr_q <= s_axi_awaddr[`ADDR_W-1:0];
         end
         if (w_take) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= known_offset(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read channel

   assign ar_take = s_axi_arvalid & arready_q;
   assign raddr = s_axi_araddr[`ADDR_W-1:0];
   assign tally_read = ar_take && (raddr == `OFF_PARITY_ERROR_COUNT);

   // unused upper bits are padded with zero
   always @* begin
      read_mux = `DATA_ZERO;
      read_ok = 1'b1;
      case (raddr)
         `OFF_PARITY_ERROR_COUNT: read_mux[`TALLY_W-1:0] = tally;
         `OFF_QUEUE_TIMEOUT_ENABLE: read_mux[`TIMEOUT_ENABLE_BIT] = timeout_enable_q;
         `OFF_TIMEOUT_REPORT_CONTROL: read_mux[`REPORT_CTRL_W-1:0] = report_ctrl_q;
         `OFF_EVENT_STATUS: read_mux[`EVENT_W-1:0] = event_status_q;
         `OFF_EVENT_MASK: read_mux[`EVENT_W-1:0] = event_mask_q;
         default: read_ok = 1'b0;
      endcase
   end

   // data is captured at the address edge, so a clearing read sees the old tally
   always @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= `DATA_ZERO;
         rresp_q <= `RESP_OKAY;
      end else begin
         if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= read_mux;
            rresp_q <= read_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers

   // only byte lane 0 carries fields; the upper lanes are reserved
   always @(posedge aclk) begin
      if (!aresetn) begin
         timeout_enable_q <= `RST_TIMEOUT_ENABLE;
         report_ctrl_q <= `RST_REPORT_CTRL;
         event_mask_q <= `RST_EVENT;
      end else if (do_write && wstrb_q[0]) begin
         case (waddr_q)
            `OFF_QUEUE_TIMEOUT_ENABLE: timeout_enable_q <= wdata_q[`TIMEOUT_ENABLE_BIT];
            `OFF_TIMEOUT_REPORT_CONTROL: report_ctrl_q <= wdata_q[`REPORT_CTRL_W-1:0];
            `OFF_EVENT_MASK: event_mask_q <= wdata_q[`EVENT_W-1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // parity error tally

   // the error strobe is a pulse of the port core on this clock, so no synchroniser
   assign parity_sync = parity_error;

   saturating_tally #(
      .WIDTH(`TALLY_W)
   ) u_tally (
      .aclk(aclk),
      .aresetn(aresetn),
      .event_hit(parity_sync),
      .read_clear(tally_read),
      .count(tally)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // queue time-out discard

   // per class: age the head packet, drop it once it has waited past the limit;
   // a limit of all ones can never be passed and so disables the drop
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_class
         always @(posedge aclk) begin
            if (!aresetn) begin
               age_q[g] <= {AGE_W{1'b0}};
               discard_q[g] <= 1'b0;
            end else begin
               discard_q[g] <= 1'b0;
               if (!timeout_enable_q || !queue_head_valid[g] || queue_head_pop[g] || discard_q[g]) begin
                  age_q[g] <= {AGE_W{1'b0}};
               end else if (age_q[g] > core_timeout_limit) begin
                  discard_q[g] <= 1'b1;
                  age_q[g] <= {AGE_W{1'b0}};
               end else begin
                  age_q[g] <= age_q[g] + {{(AGE_W-1){1'b0}}, 1'b1};
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // event status and interrupt

   assign event_set = {parity_sync, discard_q};

   // write one to clear; a new event in the same cycle keeps its bit set
   always @* begin
      event_status_d = event_status_q;
      if (do_write && wstrb_q[0] && waddr_q == `OFF_EVENT_STATUS) begin
         event_status_d = event_status_q & ~wdata_q[`EVENT_W-1:0];
      end
      event_status_d = event_status_d | event_set;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         event_status_q <= `RST_EVENT;
         irq_q <= 1'b0;
      end else begin
         event_status_q <= event_status_d;
         irq_q <= |(event_status_d & event_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // error messages to the root

   timeout_reporter u_reporter (
      .aclk(aclk),
      .aresetn(aresetn),
      .status(event_status_q[2:0]),
      .report_ctrl(report_ctrl_q),
      .msg_valid(err_msg_valid),
      .msg_code(err_msg_code)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign queue_discard = discard_q;
   assign irq = irq_q;

endmodule

// [common/port_error_defines.vh]
// register map, field layout and reset values of the port error and time-out block
`ifndef PORT_ERROR_DEFINES_VH
`define PORT_ERROR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets (low 12 address bits)
`define ADDR_W 12
`define OFF_PARITY_ERROR_COUNT 12'h04e0
`define OFF_QUEUE_TIMEOUT_ENABLE 12'h04e4
`define OFF_TIMEOUT_REPORT_CONTROL 12'h04e8
`define OFF_EVENT_STATUS 12'h04f0
`define OFF_EVENT_MASK 12'h04f4

////////////////////////////////////////////////////////////////////////////////
// field layout
`define TALLY_W 8
`define TALLY_MAX 8'hff
`define TIMEOUT_ENABLE_BIT 0
`define POSTED_REPORT_LSB 0
`define NONPOSTED_REPORT_LSB 2
`define COMPLETION_REPORT_LSB 4
`define REPORT_CTRL_W 6
`define EVENT_W 4
`define EVENT_PARITY_BIT 3

////////////////////////////////////////////////////////////////////////////////
// reset values
`define RST_TALLY 8'h00
`define RST_TIMEOUT_ENABLE 1'b1
`define RST_REPORT_CTRL 6'h02
`define RST_EVENT 4'h0

////////////////////////////////////////////////////////////////////////////////
// report encodings and bus answers
`define REPORT_NONE 2'h0
`define REPORT_COR 2'h1
`define REPORT_NONFATAL 2'h2
`define REPORT_FATAL 2'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define DATA_ZERO 32'h0000_0000

`endif

// [rtl/saturating_tally.v]
// saturating event counter with clear-on-read
`timescale 1ns/1ps
`include "port_error_defines.vh"

module saturating_tally #(
   parameter WIDTH = 8
) (
   input wire aclk,
   input wire aresetn,
   input wire event_hit,
   input wire read_clear,
   output wire [WIDTH-1:0] count
);

   reg [WIDTH-1:0] count_q;
   reg [WIDTH-1:0] count_d;

   // an error in the same cycle as the clearing read is kept as a count of one
   always @* begin
      count_d = count_q;
      if (read_clear) begin
         count_d = {WIDTH{1'b0}};
      end
      if (event_hit) begin
         if (read_clear) begin
            count_d = {{(WIDTH-1){1'b0}}, 1'b1};
         end else if (count_q != {WIDTH{1'b1}}) begin
            count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= {WIDTH{1'b0}};
      end else begin
         count_q <= count_d;
      end
   end

   assign count = count_q;

endmodule

// [rtl/timeout_reporter.v]
// turns rising time-out status bits into one error message to the root
`timescale 1ns/1ps
`include "port_error_defines.vh"

module timeout_reporter (
   input wire aclk,
   input wire aresetn,
   input wire [2:0] status,
   input wire [`REPORT_CTRL_W-1:0] report_ctrl,
   output reg msg_valid,
   output reg [1:0] msg_code
);

   reg [2:0] status_prev_q;
   reg [2:0] rising;
   reg [1:0] worst;
   integer i;

   // pick the most severe code among classes whose status just rose;
   // merging keeps a single message port at the cost of one message per cycle
   always @* begin
      rising = status & ~status_prev_q;
      worst = `REPORT_NONE;
      for (i = 0; i < 3; i = i + 1) begin
         if (rising[i] && report_ctrl[2*i +: 2] > worst) begin
            worst = report_ctrl[2*i +: 2];
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         status_prev_q <= 3'h0;
         msg_valid <= 1'b0;
         msg_code <= `REPORT_NONE;
      end else begin
         status_prev_q <= status;
         msg_valid <= (worst != `REPORT_NONE);
         msg_code <= worst;
      end
   end

endmodule

// [testbench/port_error_timeout_reporting_asserts.sv]
// port-level checks for the port error and time-out block
`timescale 1ns/1ps
module port_error_timeout_reporting_asserts #(
   parameter AGE_W = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] queue_head_valid,
   input wire [2:0] queue_discard,
   input wire err_msg_valid,
   input wire [1:0] err_msg_code
);
   // one clock domain, so one clocking and one disable for all checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////
   // time-out discard and reporting
   a_discard_cause: assert property (
      queue_discard != 3'h0 |-> (queue_discard & ~$past(queue_head_valid)) == 3'h0)
      else $error("discard without a waiting head packet");
   a_discard_pulse: assert property (
      queue_discard != 3'h0 |=> (queue_discard & $past(queue_discard)) == 3'h0)
      else $error("discard longer than one cycle");
   a_msg_code: assert property (
      err_msg_valid |-> err_msg_code != 2'h0)
      else $error("message sent for a no-report setting");
   // a message follows a discard by two edges, the status bit sits between them
   a_msg_cause: assert property (
      err_msg_valid |-> $past(queue_discard, 2) != 3'h0)
      else $error("message without a preceding discard");

   ////////////////////////////////////////
   // register bus
   a_rsvd_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("reserved read bits not zero");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed before taken");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered next cycle");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write not answered in time");
endmodule

bind port_error_timeout_reporting port_error_timeout_reporting_asserts #(.AGE_W(AGE_W)) i_chk (.*);

// [testbench/root_msg_sink.sv]
// model of the root side: takes error messages, keeps a tally and the last code
`timescale 1ns/1ps
module root_msg_sink (
   input wire aclk,
   input wire aresetn,
   input wire msg_valid,
   input wire [1:0] msg_code,
   output logic [7:0] n_msgs,
   output logic [1:0] last_code
);
   // a message stands one cycle only, so it is taken at that single edge
   always @(posedge aclk) begin
      if (!aresetn) begin
         n_msgs <= 8'h00;
         last_code <= 2'h0;
      end else if (msg_valid) begin
         n_msgs <= n_msgs + 8'h01;
         last_code <= msg_code;
      end
   end
endmodule

// [testbench/port_error_timeout_reporting_tb.sv]
// self-checking bench for the port error and time-out block
`timescale 1ns/1ps
`include "port_error_defines.vh"
module port_error_timeout_reporting_tb;
   logic aclk, aresetn, parity_error, err_msg_valid, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [1:0] s_axi_bresp, s_axi_rresp, err_msg_code, last_code;
   logic [2:0] queue_head_valid, queue_head_pop, queue_discard;
   logic [15:0] core_timeout_limit;
   logic [7:0] n_msgs;
   int miscompares, n_tests;

   port_error_timeout_reporting i_dut (.*);
   root_msg_sink i_root (.aclk(aclk), .aresetn(aresetn), .msg_valid(err_msg_valid),
      .msg_code(err_msg_code), .n_msgs(n_msgs), .last_code(last_code));

   // 10 MHz clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   ////////////////////////////////////////
   // shared tasks
   task print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ready is raised one cycle late so the slave must hold its answer
   task wr(input [11:0] a, input [31:0] d, input [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= {20'h0_0000, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask

   task rd_chk(input [11:0] a, input [31:0] exp, input [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= {20'h0_0000, a};
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, exp);
      chk(s_axi_rresp, er);
   endtask

   // parity error held n cycles counts n errors
   task par(input int n);
      @(posedge aclk);
      parity_error <= 1'b1;
      repeat (n) @(posedge aclk);
      parity_error <= 1'b0;
   endtask

   // let one head packet of class c age out; kexp is the edge it is dropped at
   task age_out(input int c, input [1:0] code, input bit clr, input [7:0] nexp, input int kexp);
      int k;
      if (clr) wr(`OFF_EVENT_STATUS, 32'h0000_000f, 2'h0);
      wr(`OFF_TIMEOUT_REPORT_CONTROL, {30'h0000_0000, code} << (2 * c), 2'h0);
      queue_head_valid[c] <= 1'b1;
      k = 0;
      while (!queue_discard[c] && k < 20) begin
         @(posedge aclk);
         k++;
      end
      queue_head_valid[c] <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(k, kexp);
      chk(n_msgs, nexp);
      if (nexp != 8'h00) chk(last_code, code);
   endtask

   ////////////////////////////////////////
   // main sequence
   initial begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hf;
      parity_error = 1'b0;
      queue_head_valid = 3'h0;
      queue_head_pop = 3'h0;
      core_timeout_limit = 16'h0004;
      aresetn = 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(`OFF_PARITY_ERROR_COUNT, 32'h0000_0000, 2'h0);
      rd_chk(`OFF_QUEUE_TIMEOUT_ENABLE, 32'h0000_0001, 2'h0);
      rd_chk(`OFF_TIMEOUT_REPORT_CONTROL, 32'h0000_0002, 2'h0);
      rd_chk(12'h0ffc, 32'h0000_0000, 2'h2);
      wr(12'h0ffc, 32'h0000_0001, 2'h2);
      $display("test reset values done");
      wr(`OFF_TIMEOUT_REPORT_CONTROL, 32'hffff_ffff, 2'h0);
      rd_chk(`OFF_TIMEOUT_REPORT_CONTROL, 32'h0000_003f, 2'h0);
      wr(`OFF_QUEUE_TIMEOUT_ENABLE, 32'hffff_ffff, 2'h0);
      rd_chk(`OFF_QUEUE_TIMEOUT_ENABLE, 32'h0000_0001, 2'h0);
      // byte lane 0 off: the write is answered but must leave the field alone
      s_axi_wstrb <= 4'h0;
      wr(`OFF_QUEUE_TIMEOUT_ENABLE, 32'h0000_0000, 2'h0);
      s_axi_wstrb <= 4'hf;
      rd_chk(`OFF_QUEUE_TIMEOUT_ENABLE, 32'h0000_0001, 2'h0);
      $display("test reserved bits done");
      par(3);
      rd_chk(`OFF_PARITY_ERROR_COUNT, 32'h0000_0003, 2'h0);
      rd_chk(`OFF_PARITY_ERROR_COUNT, 32'h0000_0000, 2'h0);
      par(300);
      rd_chk(`OFF_PARITY_ERROR_COUNT, 32'h0000_00ff, 2'h0);
      $display("test parity tally done");
      chk(irq, 1'b0);
      wr(`OFF_EVENT_MASK, 32'h0000_0008, 2'h0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b1);
      wr(`OFF_EVENT_STATUS, 32'h0000_0008, 2'h0);
      repeat (2) @(posedge aclk);
      chk(irq, 1'b0);
      $display("test interrupt done");
      // every code once, spread over the three classes
      for (int i = 0; i < 4; i++) begin
         age_out(i % 3, i[1:0], 1'b1, i[7:0], 7);
         rd_chk(`OFF_EVENT_STATUS, 32'h0000_0001 << (i % 3), 2'h0);
      end
      age_out(0, 2'h3, 1'b0, 8'h03, 7);
      // heads that leave every fourth edge never pass the limit, so no drop
      queue_head_valid[1] <= 1'b1;
      for (int j = 0; j < 20; j++) begin
         @(posedge aclk);
         queue_head_pop[1] <= (j % 4 == 3);
         chk(queue_discard[1], 1'b0);
      end
      @(posedge aclk);
      queue_head_valid[1] <= 1'b0;
      queue_head_pop[1] <= 1'b0;
      wr(`OFF_QUEUE_TIMEOUT_ENABLE, 32'h0000_0000, 2'h0);
      age_out(0, 2'h3, 1'b1, 8'h03, 20);
      rd_chk(`OFF_EVENT_STATUS, 32'h0000_0000, 2'h0);
      $display("test time-out reporting done");
      print_verdict();
   end

   // the whole run takes well under 2000 cycles
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      print_verdict();
   end
endmodule
